// [inc/egress_vid_pkg.sv]
package egress_vid_pkg;

   // =========================================================
   // Register map
   localparam int num_ports = 5;
   localparam logic [7:0] port1_ctrl_offset = 8'hb0;
   localparam logic [7:0] port2_ctrl_offset = 8'hc0;
   localparam logic [7:0] port3_ctrl_offset = 8'hd0;
   localparam logic [7:0] port4_ctrl_offset = 8'he0;
   localparam logic [7:0] port5_slot_offset = 8'hf0;
   localparam logic [7:0] unmapped_read_value = 8'h00;

   // =========================================================
   // Field layout
   localparam int reserved_one_bit = 7;
   localparam int pass_all_bit = 6;
   localparam int insert_highest_bit = 3;
   localparam int insert_second_highest_bit = 2;
   localparam int insert_second_lowest_bit = 1;
   localparam int insert_lowest_bit = 0;
   localparam logic [7:0] ctrl_write_mask = 8'h4f;
   localparam logic [7:0] ctrl_reset_value = 8'h80;

   // =========================================================
   // Tag format
   localparam logic [15:0] vlan_tpid = 16'h8100;
   localparam logic [2:0] tag_priority = 3'h0;
   localparam logic tag_dei = 1'b0;

   typedef logic [11:0] vlan_id_t;
   typedef logic [2:0] port_num_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic valid;
      port_num_t src_port;
      port_num_t egress_port;
      logic untagged;
   } frame_query_s;

   typedef struct packed {
      logic valid;
      logic insert;
      logic [31:0] tag_word;
   } insert_result_s;

endpackage : egress_vid_pkg

// [hdl/egress_rank_map.sv]
`timescale 1ns/100ps
`default_nettype none

module egress_rank_map
(
   // Frame ports, numbered 1 to 5
   input wire egress_vid_pkg::port_num_t src_port,
   input wire egress_vid_pkg::port_num_t egress_port,
   // Insert enable bit that covers this pair
   output logic [1:0] bit_index,
   output logic pair_valid
);
   import egress_vid_pkg::*;

   logic below;

   // Other ports ranked upward, source port skipped
   always_comb
   begin
      below = (src_port < egress_port);
      bit_index = 2'(egress_port - 3'd1 - {2'b00, below});
      pair_valid = (src_port != egress_port) && (src_port != 3'd0)
         && (egress_port != 3'd0) && (src_port <= 3'd5)
         && (egress_port <= 3'd5);
   end

endmodule : egress_rank_map
`default_nettype wire

// [hdl/port_egress_vid_insert_ctrl.sv]
// Behaviour
// - One control register per port at 0xb0, 0xc0, 0xd0, 0xe0; 0xf0 slot.
// - Bit 6 read/write: one makes the port pass all received frames.
// - Pass-all applies only while mirroring sniffs received traffic only.
// - Bit 3 inserts default VLAN ID toward highest other egress port.
// - Bit 2 inserts default VLAN ID toward second-highest other egress port.
// - Bit 1 inserts default VLAN ID toward second-lowest other egress port.
// - Egress ranking skips the source port itself.
// - Insertion bits act only while the global insertion gate is set.
`timescale 1ns/100ps
`default_nettype none

module port_egress_vid_insert_ctrl
(
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clk_en,
   // Register access port
   input wire egress_vid_pkg::reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Switch-wide settings
   input wire logic global_insert_en,
   input wire logic rx_sniff_only,
   input wire egress_vid_pkg::vlan_id_t port_default_vlan_id [5],
   // Forwarding decision
   input wire egress_vid_pkg::frame_query_s frame_query,
   output egress_vid_pkg::insert_result_s insert_result,
   // Per-port pass-all and insert enable outputs
   output logic [4:0] pass_all_frames,
   output logic [4:0][3:0] insert_enables
);
   import egress_vid_pkg::*;

   typedef struct packed {
      logic [4:0][7:0] ctrl;
      logic [7:0] rdata;
      logic rvalid;
      insert_result_s result;
      logic [4:0] pass_all;
   } state_s;

   state_s state_reg;
   state_s state_next;

   localparam logic [4:0][7:0] port_offsets = {port5_slot_offset,
      port4_ctrl_offset, port3_ctrl_offset, port2_ctrl_offset,
      port1_ctrl_offset};

   logic [4:0] hit;
   logic [7:0] read_view [5];
   logic [1:0] rank_bit;
   logic rank_ok;

   // ==========================================================
   // Address decode and read view per port
   genvar gi;
   generate
      for (gi = 0; gi < num_ports; gi++)
      begin : g_port
         assign hit[gi] = (reg_req.addr == port_offsets[gi]);
         // Reserved bits forced to their fixed values
         assign read_view[gi] = (state_reg.ctrl[gi] & ctrl_write_mask)
            | (ctrl_reset_value & ~ctrl_write_mask);
      end
   endgenerate

   egress_rank_map u_rank
   (
      .src_port(frame_query.src_port),
      .egress_port(frame_query.egress_port),
      .bit_index(rank_bit),
      .pair_valid(rank_ok)
   );

   // ==========================================================
   // Next state
   always_comb
   begin
      int unsigned src_idx;
      logic [3:0] en_bits;
      vlan_id_t vid;
      src_idx = 0;
      en_bits = 4'h0;
      vid = 12'h000;
      state_next = state_reg;

      // Register writes and reads
      state_next.rvalid = reg_req.rd;
      state_next.rdata = unmapped_read_value;
      for (int i = 0; i < num_ports; i++)
      begin
         if (reg_req.wr && hit[i])
         begin
            state_next.ctrl[i] = (reg_req.wdata & ctrl_write_mask)
               | (ctrl_reset_value & ~ctrl_write_mask);
         end
         if (reg_req.rd && hit[i])
         begin
            state_next.rdata = read_view[i];
         end
      end

      // Pass-all gated by receive-only sniffing
      for (int i = 0; i < num_ports; i++)
      begin
         state_next.pass_all[i] = state_reg.ctrl[i][pass_all_bit]
            && rx_sniff_only;
      end

      // Insertion decision for one frame
      if (frame_query.src_port >= 3'd1 && frame_query.src_port <= 3'd5)
      begin
         src_idx = 32'(frame_query.src_port) - 1;
      end
      en_bits = state_reg.ctrl[src_idx][insert_highest_bit:insert_lowest_bit];
      vid = port_default_vlan_id[src_idx];
      state_next.result.valid = frame_query.valid;
      // Bit 3 highest, 2, 1, 0 lowest other egress
      state_next.result.insert = frame_query.valid && rank_ok
         && global_insert_en
         && frame_query.untagged
         && en_bits[rank_bit];
      state_next.result.tag_word = {vlan_tpid, tag_priority, tag_dei,
         vid};
      if (!state_next.result.insert)
      begin
         state_next.result.tag_word = 32'h0000_0000;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_reg.ctrl <= {num_ports{ctrl_reset_value}};
         state_reg.rdata <= 8'h00;
         state_reg.rvalid <= 1'b0;
         state_reg.result <= '0;
         state_reg.pass_all <= 5'h00;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata = state_reg.rdata;
   assign reg_rvalid = state_reg.rvalid;
   assign insert_result = state_reg.result;
   assign pass_all_frames = state_reg.pass_all;
   generate
      for (gi = 0; gi < num_ports; gi++)
      begin : g_out
         assign insert_enables[gi] = state_reg.ctrl[gi][3:0];
      end
   endgenerate

endmodule : port_egress_vid_insert_ctrl
`default_nettype wire

// [testbench/egress_vid_chk_sva.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checks
module egress_vid_chk
(
   // Clock, reset, register and frame ports
   input wire logic sys_clk,
   input wire logic srst,
   input wire egress_vid_pkg::reg_req_s reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic global_insert_en,
   input wire logic rx_sniff_only,
   input wire egress_vid_pkg::frame_query_s frame_query,
   input wire egress_vid_pkg::insert_result_s insert_result,
   input wire logic [4:0] pass_all_frames
);
   import egress_vid_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   property p_rv; reg_req.rd |=> reg_rvalid; endproperty
   a_rv: assert property (p_rv) else $error("rvalid");
   property p_um; reg_req.rd && reg_req.addr == 8'h00 |=> !reg_rdata;
   endproperty
   a_um: assert property (p_um) else $error("unmapped");
   property p_pa; |pass_all_frames |-> $past(rx_sniff_only); endproperty
   a_pa: assert property (p_pa) else $error("pass all");
   property p_gt; insert_result.insert |-> $past(global_insert_en); endproperty
   a_gt: assert property (p_gt) else $error("gate");
   property p_tg; insert_result.insert |-> $past(frame_query.untagged);
   endproperty
   a_tg: assert property (p_tg) else $error("tagged");
   property p_tp; insert_result.insert |->
      insert_result.tag_word[31:16] == 16'h8100; endproperty
   a_tp: assert property (p_tp) else $error("tpid");
   property p_sf; frame_query.valid && frame_query.src_port ==
      frame_query.egress_port |=> !insert_result.insert; endproperty
   a_sf: assert property (p_sf) else $error("self");
   property p_qv; frame_query.valid |=> insert_result.valid; endproperty
   a_qv: assert property (p_qv) else $error("answer");
endmodule : egress_vid_chk
bind port_egress_vid_insert_ctrl egress_vid_chk i_chk (.*);
`default_nettype wire

// [testbench/tb_port_egress_vid_insert_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench
module tb_port_egress_vid_insert_ctrl;
   import egress_vid_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic clk_en = 1'b1;
   logic [4:0][3:0] insert_enables;
   logic global_insert_en = 1'b0;
   logic rx_sniff_only = 1'b0;
   reg_req_s reg_req = '0;
   frame_query_s frame_query = '0;
   vlan_id_t port_default_vlan_id [5];
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   insert_result_s insert_result;
   logic [4:0] pass_all_frames;
   int mismatches = 0;
   int check_count = 0;
   always #50 sys_clk = ~sys_clk;
   port_egress_vid_insert_ctrl i_dut (.*);
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge sys_clk);
      reg_req = '{1'b1, 1'b0, a, d};
      @(negedge sys_clk);
      reg_req = '0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(negedge sys_clk);
      reg_req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge sys_clk);
      reg_req = '0;
      chk("rvalid", 1, 32'(reg_rvalid));
      chk("rdata", 32'(e), 32'(reg_rdata));
   endtask : rd
   task automatic qry(int s, int g, logic u, logic e);
      @(negedge sys_clk);
      frame_query = '{1'b1, 3'(s), 3'(g), u};
      @(negedge sys_clk);
      frame_query = '0;
      chk("valid", 1, 32'(insert_result.valid));
      chk("insert", 32'(e), 32'(insert_result.insert));
      chk("tag", e ? {16'h8100, 4'h0, port_default_vlan_id[s - 1]} : 0,
         insert_result.tag_word);
   endtask : qry
   task automatic close_out;
      if (mismatches == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   initial
   begin
      for (int i = 0; i < 5; i++)
         port_default_vlan_id[i] = 12'ha01 + 12'(i);
      repeat (20) @(negedge sys_clk);
      srst = 1'b0;
      for (int i = 0; i < 6; i++)
         rd(8'hb0 + 8'(i) * 8'h10, i < 5 ? 8'h80 : 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         wr(8'hb0 + 8'(i) * 8'h10, 8'hff);
         rd(8'hb0 + 8'(i) * 8'h10, 8'hcf);
      end
      rx_sniff_only = 1'b1;
      @(negedge sys_clk);
      chk("pass", 32'h1f, 32'(pass_all_frames));
      rx_sniff_only = 1'b0;
      @(negedge sys_clk);
      chk("pass", 0, 32'(pass_all_frames));
      global_insert_en = 1'b1;
      for (int b = 0; b < 4; b++)
      begin
         for (int p = 0; p < 5; p++)
            wr(8'hb0 + 8'(p) * 8'h10, 8'h01 << b);
         for (int s = 1; s < 6; s++)
            for (int g = 1; g < 6; g++)
               qry(s, g, 1'b1, s != g && g - 1 - (s < g) == b);
      end
      qry(5, 4, 1'b0, 1'b0);
      global_insert_en = 1'b0;
      qry(5, 4, 1'b1, 1'b0);
      chk("enables", 32'h88888, 32'(insert_enables));
      qry(6, 1, 1'b1, 1'b0);
      qry(1, 7, 1'b1, 1'b0);
      clk_en = 1'b0;
      wr(8'hb0, 8'h41);
      clk_en = 1'b1;
      rd(8'hb0, 8'h88);
      @(negedge sys_clk);
      srst = 1'b1;
      repeat (2) @(negedge sys_clk);
      srst = 1'b0;
      rd(8'hc0, 8'h80);
      chk("enables", 0, 32'(insert_enables));
      close_out();
   end
   initial
   begin
      #200000;
      mismatches++;
      close_out();
   end
endmodule : tb_port_egress_vid_insert_ctrl
`default_nettype wire
